// ===== src/css_switch.sv
// clock source switching controller with rc trim register
// assumes oscillator ticks, stable flags and pll lock are synchronous to clock_in
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module css_switch (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire css_pkg::css_cfg_s cfg_in,
	input wire logic [1:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [3:0] src_tick_in,
	input wire logic [3:0] src_stable_in,
	input wire logic pll_lock_in,
	input wire logic clock_fail_in,
	output logic [15:0] rdata_out,
	output logic [3:0] osc_enable_out,
	output logic pll_enable_out,
	output logic [2:0] sys_clk_sel_out,
	output logic [5:0] rc_trim_code_out,
	output logic switch_busy_out
);

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_CHECK = 6'b000010,
		ST_WAIT_RDY = 6'b000100,
		ST_WAIT_PLL = 6'b001000,
		ST_COUNT = 6'b010000,
		ST_DONE = 6'b100000
	} css_state_e;

	css_state_e state_q, state_d;
	logic [2:0] cur_q, next_q;
	logic req_q, lock_q, fail_q, sec_en_q;
	logic [5:0] trim_q;
	logic [3:0] osc_en_q, osc_en_d;
	logic [1:0] unl_q [2], unl_d [2];
	logic [1:0] open_w;

	////////////////////////////////////////////////////////////////////////
	// decode
	logic sw_en, any_strobe, wr_hi_ok, wr_lo_ok, tgt_pll, tgt_stable;
	logic count_start, count_done, accept, keep_lowpower_rc_osc;
	logic [1:0] tgt_idx, old_idx;
	logic [15:0] ctrl_word, rdata_d;

	assign sw_en = (cfg_in.switch_monitor_cfg == css_pkg::CFG_SWITCH_ON);
	assign any_strobe = wr_in | rd_in;
	assign tgt_idx = css_pkg::css_src_idx(next_q);
	assign old_idx = css_pkg::css_src_idx(cur_q);
	assign tgt_pll = css_pkg::css_is_pll(next_q);
	assign tgt_stable = src_stable_in[tgt_idx];
	// monitor runs whenever switching is configured on
	assign keep_lowpower_rc_osc = cfg_in.watchdog_en | sw_en;
	assign accept = (state_q == ST_CHECK) && (cur_q != next_q) && css_pkg::css_code_ok(next_q);
	// an unlocked byte takes exactly the next access
	assign wr_lo_ok = wr_in && (addr_in == css_pkg::ADDR_CTRL_LO) && open_w[0];
	assign wr_hi_ok = wr_in && (addr_in == css_pkg::ADDR_CTRL_HI) && open_w[1];

	////////////////////////////////////////////////////////////////////////
	// unlock trackers, byte 0 low, byte 1 high
	for (genvar g = 0; g < 2; g++) begin : g_unlock
		localparam logic [1:0] BYTE_ADDR = (g == 0) ? css_pkg::ADDR_CTRL_LO : css_pkg::ADDR_CTRL_HI;
		localparam logic [7:0] K1 = (g == 0) ? css_pkg::KEY1_LO : css_pkg::KEY1_HI;
		localparam logic [7:0] K2 = (g == 0) ? css_pkg::KEY2_LO : css_pkg::KEY2_HI;
		logic own_wr;
		assign own_wr = wr_in && (addr_in == BYTE_ADDR);
		assign open_w[g] = (unl_q[g] == 2'h2);
		// two keys back to back, any other access restarts
		assign unl_d[g] = !any_strobe ? unl_q[g] :
			(own_wr && unl_q[g] == 2'h1 && wdata_in[7:0] == K2) ? 2'h2 :
			(own_wr && wdata_in[7:0] == K1 && unl_q[g] != 2'h2) ? 2'h1 : 2'h0;
		always_ff @(posedge clock_in) begin
			if (sys_rst_in) begin
				unl_q[g] <= 2'h0;
			end else begin
				unl_q[g] <= unl_d[g];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// switch sequencer
	// state decode kept combinational; the old clock stays selected throughout
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				// a set request starts the sequence
				if (req_q) begin
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: state_d = accept ? ST_WAIT_RDY : ST_IDLE;
			ST_WAIT_RDY: begin
				// wait for start-up timer or oscillator stable
				if (tgt_stable) begin
					state_d = tgt_pll ? ST_WAIT_PLL : ST_COUNT;
				end
			end
			ST_WAIT_PLL: begin
				// hold until the pll reports lock
				if (lock_q) begin
					state_d = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (count_done) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	assign count_start = (state_d == ST_COUNT) && (state_q != ST_COUNT);
	// ten ticks of the new source before changeover
	css_tick_count #(
		.TICKS(css_pkg::NEW_CLK_WAIT_CYCLES)
	) u_tick_count (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.start_in(count_start),
		.tick_in(src_tick_in[tgt_idx]),
		.done_out(count_done)
	);

	// after changeover only the new source and the exempt ones stay on
	always_comb begin
		osc_en_d = osc_en_q;
		if (state_q == ST_CHECK && accept) begin
			osc_en_d[tgt_idx] = 1'b1;
		end else if (state_q == ST_DONE) begin
			osc_en_d = 4'h0;
			osc_en_d[css_pkg::SRC_LOWPOWER_RC_OSC] = osc_en_q[css_pkg::SRC_LOWPOWER_RC_OSC] & keep_lowpower_rc_osc;
			osc_en_d[css_pkg::SRC_SEC] = osc_en_q[css_pkg::SRC_SEC] & sec_en_q;
			// target last, so an exempt-source rule cannot switch it off
			osc_en_d[tgt_idx] = 1'b1;
		end else if (!sw_en) begin
			osc_en_d = 4'h0;
			osc_en_d[css_pkg::css_src_idx(cfg_in.powerup_source_cfg)] = 1'b1;
		end else begin
			// the source the system runs on is never left off
			osc_en_d[old_idx] = 1'b1;
		end
		if (sec_en_q) begin
			osc_en_d[css_pkg::SRC_SEC] = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_q <= ST_IDLE;
			osc_en_q <= 4'h0;
		end else begin
			state_q <= state_d;
			osc_en_q <= osc_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source fields and request
	// current source follows configuration while switching is off
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cur_q <= cfg_in.powerup_source_cfg;
			next_q <= cfg_in.powerup_source_cfg;
		end else if (!sw_en) begin
			cur_q <= cfg_in.powerup_source_cfg;
			next_q <= cfg_in.powerup_source_cfg;
		end else begin
			// copy next into current at changeover
			if (state_q == ST_DONE) begin
				cur_q <= next_q;
			end
			// only the source code is writable, never the submode
			if (wr_hi_ok && state_q == ST_IDLE && !req_q) begin
				next_q <= wdata_in[css_pkg::NEXT_LSB - 8 +: 3];
			end
		end
	end

	// request held low when switching is disabled
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || !sw_en) begin
			req_q <= 1'b0;
		end else if ((state_q == ST_CHECK && !accept) || state_q == ST_DONE) begin
			// hardware clears request on abort or success
			req_q <= 1'b0;
		end else if (wr_lo_ok && wdata_in[css_pkg::REQ_BIT]) begin
			req_q <= 1'b1;
		end
	end

	// lock and fail flags cleared on a valid switch; a fresh clock fail wins, a fresh lock does not
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			lock_q <= 1'b0;
			fail_q <= 1'b0;
			sec_en_q <= 1'b0;
		end else begin
			lock_q <= pll_enable_out & pll_lock_in & ~accept;
			if (clock_fail_in && sw_en) begin
				fail_q <= 1'b1;
			end else if (accept || (wr_lo_ok && !wdata_in[css_pkg::FAIL_BIT])) begin
				fail_q <= 1'b0;
			end
			if (wr_lo_ok) begin
				sec_en_q <= wdata_in[css_pkg::SEC_EN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trim register and read port
	// signed trim code, zero is the centre frequency
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			trim_q <= css_pkg::TRIM_RESET;
		end else if (wr_in && addr_in == css_pkg::ADDR_FRC_TUNE) begin
			trim_q <= wdata_in[5:0];
		end
	end

	assign ctrl_word = {1'b0, cur_q, 1'b0, next_q, 2'h0, lock_q, 1'b0, fail_q, 1'b0,
		sec_en_q, req_q};
	// read data exist only in the cycle after the strobe
	assign rdata_d = !rd_in ? 16'h0000 :
		(addr_in == css_pkg::ADDR_CTRL) ? ctrl_word :
		(addr_in == css_pkg::ADDR_CTRL_HI) ? {8'h00, ctrl_word[15:8]} :
		(addr_in == css_pkg::ADDR_CTRL_LO) ? {8'h00, ctrl_word[7:0]} :
		{10'h000, trim_q};

	// system clock selection moves only at the changeover
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			rdata_out <= 16'h0000;
			sys_clk_sel_out <= 3'h0;
			pll_enable_out <= 1'b0;
			switch_busy_out <= 1'b0;
		end else begin
			rdata_out <= rdata_d;
			sys_clk_sel_out <= (state_q == ST_DONE) ? next_q : cur_q;
			pll_enable_out <= css_pkg::css_is_pll(cur_q) |
				(tgt_pll & (state_q != ST_IDLE) & (state_q != ST_CHECK));
			switch_busy_out <= (state_d != ST_IDLE);
		end
	end

	assign osc_enable_out = osc_en_q;
	assign rc_trim_code_out = trim_q;

	////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_hi_unlock;
		wr_in && addr_in == css_pkg::ADDR_CTRL_HI && wdata_in[7:0] == css_pkg::KEY1_HI
		##1 wr_in && addr_in == css_pkg::ADDR_CTRL_HI && wdata_in[7:0] == css_pkg::KEY2_HI;
	endsequence
	sequence s_lo_unlock;
		wr_in && addr_in == css_pkg::ADDR_CTRL_LO && wdata_in[7:0] == css_pkg::KEY1_LO
		##1 wr_in && addr_in == css_pkg::ADDR_CTRL_LO && wdata_in[7:0] == css_pkg::KEY2_LO;
	endsequence

	property p_trim_read;
		@(posedge clock_in) disable iff (sys_rst_in)
		rd_in && addr_in == css_pkg::ADDR_FRC_TUNE |=> rdata_out == {10'h000, $past(trim_q)};
	endproperty
	a_trim_read: assert property (p_trim_read) else $error("trim readback wrong");
	property p_req_held;
		@(posedge clock_in) disable iff (sys_rst_in)
		!sw_en |=> !req_q;
	endproperty
	a_req_held: assert property (p_req_held) else $error("request set while disabled");
	property p_cur_cfg;
		@(posedge clock_in) disable iff (sys_rst_in)
		!sw_en |=> cur_q == $past(cfg_in.powerup_source_cfg);
	endproperty
	a_cur_cfg: assert property (p_cur_cfg) else $error("current source not from config");
	property p_hi_write;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_hi_unlock ##1 (wr_in && addr_in == css_pkg::ADDR_CTRL_HI && sw_en && !req_q
			&& state_q == ST_IDLE) |=> next_q == $past(wdata_in[2:0]);
	endproperty
	a_hi_write: assert property (p_hi_write) else $error("unlocked high write lost");
	property p_lo_write;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_lo_unlock ##1 (wr_in && addr_in == css_pkg::ADDR_CTRL_LO && wdata_in[0] && sw_en
			&& state_q == ST_IDLE) |=> req_q;
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("unlocked request write lost");
	property p_locked_hi;
		@(posedge clock_in) disable iff (sys_rst_in)
		wr_in && addr_in == css_pkg::ADDR_CTRL_HI && !open_w[1] && sw_en |=> $stable(next_q);
	endproperty
	a_locked_hi: assert property (p_locked_hi) else $error("locked high byte changed");
	property p_redundant;
		@(posedge clock_in) disable iff (sys_rst_in)
		state_q == ST_CHECK && cur_q == next_q |=> !req_q && state_q == ST_IDLE
			&& $stable(cur_q);
	endproperty
	a_redundant: assert property (p_redundant) else $error("redundant switch not aborted");
	property p_flags_clear;
		@(posedge clock_in) disable iff (sys_rst_in)
		accept && !clock_fail_in |=> !lock_q && !fail_q;
	endproperty
	a_flags_clear: assert property (p_flags_clear) else $error("flags kept on switch");
	property p_target_on;
		@(posedge clock_in) disable iff (sys_rst_in)
		accept |=> osc_enable_out[$past(tgt_idx)] && state_q == ST_WAIT_RDY;
	endproperty
	a_target_on: assert property (p_target_on) else $error("target not enabled");
	property p_pll_wait;
		@(posedge clock_in) disable iff (sys_rst_in)
		state_q == ST_WAIT_PLL && !lock_q |=> state_q == ST_WAIT_PLL;
	endproperty
	a_pll_wait: assert property (p_pll_wait) else $error("left pll wait unlocked");
	property p_done;
		@(posedge clock_in) disable iff (sys_rst_in)
		state_q == ST_DONE |=> cur_q == $past(next_q) && !req_q
			&& sys_clk_sel_out == $past(next_q);
	endproperty
	a_done: assert property (p_done) else $error("changeover status wrong");
	property p_old_clock;
		@(posedge clock_in) disable iff (sys_rst_in)
		sw_en && state_q != ST_DONE && $past(sw_en) |=> $stable(cur_q);
	endproperty
	a_old_clock: assert property (p_old_clock) else $error("source moved early");

endmodule // css_switch

`default_nettype wire

// ===== src/css_pkg.sv
// constants, field layout and carrier types of the clock source switcher
// assumes one 25 MHz system clock, synchronous active-high reset, 16-bit register port
//
// Behaviour
// - six-bit signed rc trim code, 011111 fastest, 100000 slowest, zero centre
// - switching allowed only when switch monitor config is 00; 1x disables it
// - switching disabled: next source ignored, current source follows power-up config
// - switching disabled: switch request held at zero, writes have no effect
// - four sources selectable; primary submode fixed by configuration only
// - high byte needs 78h then 9Ah, then next write only is accepted
// - low byte needs 46h then 57h, then next write only is accepted
// - setting switch request starts a switch to the next source
// - equal current and next source: clear request, abort without change
// - valid switch clears pll lock status and clock fail flag
// - enable target source and wait for its start-up to finish
// - pll target: wait for pll lock status before going on
// - count ten new-clock cycles, then move system clock glitch-free
// - on completion clear request and copy next source into current source
// - old source off, except low-power rc for monitors, secondary when enabled
// - processor keeps running on old clock until the changeover

package css_pkg;

	// register port addresses
	localparam logic [1:0] ADDR_CTRL_LO = 2'h0;
	localparam logic [1:0] ADDR_CTRL_HI = 2'h1;
	localparam logic [1:0] ADDR_CTRL = 2'h2;
	localparam logic [1:0] ADDR_FRC_TUNE = 2'h3;

	// unlock keys, index 0 low byte, index 1 high byte
	localparam logic [7:0] KEY1_LO = 8'h46;
	localparam logic [7:0] KEY2_LO = 8'h57;
	localparam logic [7:0] KEY1_HI = 8'h78;
	localparam logic [7:0] KEY2_HI = 8'h9A;

	// control register bit positions
	localparam int CUR_LSB = 12;
	localparam int NEXT_LSB = 8;
	localparam int LOCK_BIT = 5;
	localparam int FAIL_BIT = 3;
	localparam int SEC_EN_BIT = 1;
	localparam int REQ_BIT = 0;

	// source codes of the current and next source fields
	localparam logic [2:0] CODE_FRC = 3'h0;
	localparam logic [2:0] CODE_FRC_PLL = 3'h1;
	localparam logic [2:0] CODE_PRI = 3'h2;
	localparam logic [2:0] CODE_PRI_PLL = 3'h3;
	localparam logic [2:0] CODE_SEC = 3'h4;
	localparam logic [2:0] CODE_LOWPOWER_RC_OSC = 3'h5;

	// oscillator enable / tick indices
	localparam logic [1:0] SRC_FRC = 2'h0;
	localparam logic [1:0] SRC_PRI = 2'h1;
	localparam logic [1:0] SRC_SEC = 2'h2;
	localparam logic [1:0] SRC_LOWPOWER_RC_OSC = 2'h3;

	localparam logic [1:0] CFG_SWITCH_ON = 2'h0;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam int NEW_CLK_WAIT_CYCLES = 10;

	// configuration word fields, fixed while running
	typedef struct packed {
		logic [1:0] switch_monitor_cfg;
		logic [2:0] powerup_source_cfg;
		logic [1:0] primary_submode_cfg;
		logic watchdog_en;
	} css_cfg_s;

	function automatic logic [1:0] css_src_idx(input logic [2:0] code);
		css_src_idx = (code == CODE_SEC) ? SRC_SEC :
			(code == CODE_LOWPOWER_RC_OSC) ? SRC_LOWPOWER_RC_OSC :
			(code == CODE_PRI || code == CODE_PRI_PLL) ? SRC_PRI : SRC_FRC;
	endfunction

	function automatic logic css_is_pll(input logic [2:0] code);
		css_is_pll = (code == CODE_FRC_PLL) || (code == CODE_PRI_PLL);
	endfunction

	function automatic logic css_code_ok(input logic [2:0] code);
		css_code_ok = (code <= CODE_LOWPOWER_RC_OSC);
	endfunction

endpackage

// ===== src/css_tick_count.sv
// counter of new-source clock ticks before a changeover
// assumes tick_in is a one-cycle pulse per new-source cycle, synchronous to clock_in
`timescale 1ns/1ns
`default_nettype none

module css_tick_count #(
	parameter int TICKS = css_pkg::NEW_CLK_WAIT_CYCLES
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic tick_in,
	output logic done_out
);

	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic run_q;
	logic last_tick;

	// final tick of the run ends it with a one-cycle done
	assign last_tick = run_q && tick_in && (cnt_q == 5'(TICKS - 1));
	assign cnt_d = start_in ? 5'h00 : (run_q && tick_in) ? cnt_q + 5'h01 : cnt_q;

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cnt_q <= 5'h00;
			run_q <= 1'b0;
			done_out <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= start_in | (run_q & ~last_tick);
			done_out <= last_tick;
		end
	end

endmodule // css_tick_count

`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the clock source switcher
// assumes a 25 MHz clock, synchronous active-high reset, no partner model
`timescale 1ns/1ns
`default_nettype none

module tb_top;

	logic clock_in;
	logic sys_rst_in;
	css_pkg::css_cfg_s cfg_in;
	logic [1:0] addr_in;
	logic [15:0] wdata_in;
	logic wr_in;
	logic rd_in;
	logic [3:0] src_tick_in;
	logic [3:0] src_stable_in;
	logic pll_lock_in;
	logic clock_fail_in;
	logic [15:0] rdata_out;
	logic [3:0] osc_enable_out;
	logic pll_enable_out;
	logic [2:0] sys_clk_sel_out;
	logic [5:0] rc_trim_code_out;
	logic switch_busy_out;
	int n_mismatch;
	int checks_done;
	int cyc;
	logic [15:0] q;
	// trim rows: written value beside expected read-back
	logic [15:0] trim_w [4] = '{16'h001F, 16'h0020, 16'hFFE0, 16'h0000};
	logic [15:0] trim_e [4] = '{16'h001F, 16'h0020, 16'h0020, 16'h0000};
	localparam logic [15:0] M_BASE = 16'h7701;

	css_switch i_dut (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.cfg_in(cfg_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.src_tick_in(src_tick_in),
		.src_stable_in(src_stable_in),
		.pll_lock_in(pll_lock_in),
		.clock_fail_in(clock_fail_in),
		.rdata_out(rdata_out),
		.osc_enable_out(osc_enable_out),
		.pll_enable_out(pll_enable_out),
		.sys_clk_sel_out(sys_clk_sel_out),
		.rc_trim_code_out(rc_trim_code_out),
		.switch_busy_out(switch_busy_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// clock, source ticks and hang guard
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// every source ticks every other system cycle, so ten ticks take twenty cycles
	always @(posedge clock_in) begin
		src_tick_in <= ~src_tick_in;
	end

	// ceiling well above the few hundred cycles the sequence needs
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, report and bus tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmp_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_port(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		rd_in <= 1'b0;
		@(posedge clock_in);
	endtask

	// data stand only in the cycle after the strobe, so sample there
	task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		wr_in <= 1'b0;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
		@(posedge clock_in);
	endtask

	task automatic bus_idle(input int n);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
		repeat (n) @(posedge clock_in);
	endtask

	task automatic rd_chk(input logic [1:0] a, input logic [15:0] m, input logic [15:0] e);
		bus_rd(a, q);
		cmp_reg("register read", e & m, q & m);
	endtask

	function automatic logic [15:0] ctrl(input logic [2:0] c, input logic [2:0] n,
		input logic lk, input logic fl, input logic rq);
		logic [15:0] v;
		v = 16'h0000;
		v[css_pkg::CUR_LSB +: 3] = c;
		v[css_pkg::NEXT_LSB +: 3] = n;
		v[css_pkg::LOCK_BIT] = lk;
		v[css_pkg::FAIL_BIT] = fl;
		v[css_pkg::REQ_BIT] = rq;
		return v;
	endfunction

	// both unlock sequences, next source, then the low byte value
	task automatic req_switch(input logic [2:0] code, input logic [7:0] lo);
		// keys and writes back to back, nothing in between
		bus_wr(css_pkg::ADDR_CTRL_HI, 16'h0078);
		bus_wr(css_pkg::ADDR_CTRL_HI, 16'h009A);
		bus_wr(css_pkg::ADDR_CTRL_HI, {13'h0000, code});
		bus_wr(css_pkg::ADDR_CTRL_LO, 16'h0046);
		bus_wr(css_pkg::ADDR_CTRL_LO, 16'h0057);
		bus_wr(css_pkg::ADDR_CTRL_LO, {8'h00, lo});
		bus_idle(1);
	endtask

	task automatic wait_busy(input logic v, input int lim);
		int k;
		k = 0;
		while (switch_busy_out !== v && k < lim) begin
			@(posedge clock_in);
			k++;
		end
		cmp_port("switch_busy_out", {15'h0000, v}, {15'h0000, switch_busy_out});
	endtask

	task automatic do_reset(input css_pkg::css_cfg_s c);
		sys_rst_in <= 1'b1;
		cfg_in <= c;
		repeat (2) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		@(posedge clock_in);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		sys_rst_in = 1'b1;
		cfg_in = 8'h01;
		addr_in = 2'h0;
		wdata_in = 16'h0000;
		wr_in = 1'b0;
		rd_in = 1'b0;
		src_tick_in = 4'h0;
		src_stable_in = 4'h1;
		pll_lock_in = 1'b0;
		clock_fail_in = 1'b0;
		n_mismatch = 0;
		checks_done = 0;
		cyc = 0;
		// switching on, fast rc at power-up, watchdog on
		do_reset({2'h0, css_pkg::CODE_FRC, 2'h0, 1'b1});
		rd_chk(css_pkg::ADDR_CTRL, M_BASE, ctrl(3'h0, 3'h0, 1'b0, 1'b0, 1'b0));
		cmp_port("osc_enable_frc", 16'h0001, {15'h0000, osc_enable_out[0]});
		// trim table, upper bits never stored
		for (int i = 0; i < 4; i++) begin
			bus_wr(css_pkg::ADDR_FRC_TUNE, trim_w[i]);
			bus_rd(css_pkg::ADDR_FRC_TUNE, q);
			cmp_reg("frc_tune", trim_e[i], q);
			cmp_port("rc_trim_code_out", trim_e[i], {10'h000, rc_trim_code_out});
		end
		// a read between the keys breaks the high unlock
		bus_wr(css_pkg::ADDR_CTRL_HI, 16'h0078);
		bus_rd(css_pkg::ADDR_CTRL_LO, q);
		bus_wr(css_pkg::ADDR_CTRL_HI, 16'h009A);
		bus_wr(css_pkg::ADDR_CTRL_HI, 16'h0002);
		// another write between the keys breaks the low unlock
		bus_wr(css_pkg::ADDR_CTRL_LO, 16'h0046);
		bus_wr(css_pkg::ADDR_CTRL_HI, 16'h0000);
		bus_wr(css_pkg::ADDR_CTRL_LO, 16'h0057);
		bus_wr(css_pkg::ADDR_CTRL_LO, 16'h0001);
		bus_idle(2);
		rd_chk(css_pkg::ADDR_CTRL, M_BASE, ctrl(3'h0, 3'h0, 1'b0, 1'b0, 1'b0));
		cmp_port("switch_busy_out", 16'h0000, {15'h0000, switch_busy_out});
		// fail flag set, then cleared by a valid switch to primary
		clock_fail_in <= 1'b1;
		@(posedge clock_in);
		clock_fail_in <= 1'b0;
		bus_idle(1);
		rd_chk(css_pkg::ADDR_CTRL, 16'h0008, 16'h0008);
		// request write keeps the fail bit at one, so only acceptance can clear it
		req_switch(css_pkg::CODE_PRI, 8'h09);
		wait_busy(1'b1, 10);
		repeat (6) @(posedge clock_in);
		cmp_port("osc_enable_pri", 16'h0001, {15'h0000, osc_enable_out[1]});
		cmp_port("sys_clk_sel_out", 16'h0000, {13'h0000, sys_clk_sel_out});
		rd_chk(css_pkg::ADDR_CTRL, 16'h0709, ctrl(3'h0, 3'h2, 1'b0, 1'b0, 1'b1));
		src_stable_in <= 4'h3;
		repeat (12) @(posedge clock_in);
		cmp_port("sys_clk_sel_out", 16'h0000, {13'h0000, sys_clk_sel_out});
		wait_busy(1'b0, 60);
		bus_idle(1);
		cmp_port("sys_clk_sel_out", 16'h0002, {13'h0000, sys_clk_sel_out});
		cmp_port("osc_enable_frc", 16'h0000, {15'h0000, osc_enable_out[0]});
		rd_chk(css_pkg::ADDR_CTRL, M_BASE, ctrl(3'h2, 3'h2, 1'b0, 1'b0, 1'b0));
		// redundant request: cleared, busy back low after a one-cycle pulse, clock unchanged
		req_switch(css_pkg::CODE_PRI, 8'h01);
		bus_idle(4);
		cmp_port("switch_busy_out", 16'h0000, {15'h0000, switch_busy_out});
		rd_chk(css_pkg::ADDR_CTRL, M_BASE, ctrl(3'h2, 3'h2, 1'b0, 1'b0, 1'b0));
		// pll target waits for lock however long it takes
		// pll mode entered from plain primary, never from the fast rc pll mode
		req_switch(css_pkg::CODE_PRI_PLL, 8'h01);
		wait_busy(1'b1, 10);
		repeat (30) @(posedge clock_in);
		cmp_port("pll_enable_out", 16'h0001, {15'h0000, pll_enable_out});
		cmp_port("sys_clk_sel_out", 16'h0002, {13'h0000, sys_clk_sel_out});
		rd_chk(css_pkg::ADDR_CTRL, 16'h0721, ctrl(3'h2, 3'h3, 1'b0, 1'b0, 1'b1));
		pll_lock_in <= 1'b1;
		wait_busy(1'b0, 80);
		bus_idle(1);
		cmp_port("sys_clk_sel_out", 16'h0003, {13'h0000, sys_clk_sel_out});
		rd_chk(css_pkg::ADDR_CTRL, M_BASE, ctrl(3'h3, 3'h3, 1'b0, 1'b0, 1'b0));
		// switching off: secondary at power-up, request and next ignored
		pll_lock_in <= 1'b0;
		src_stable_in <= 4'h4;
		do_reset({2'h2, css_pkg::CODE_SEC, 2'h0, 1'b0});
		bus_idle(2);
		rd_chk(css_pkg::ADDR_CTRL, 16'h7001, ctrl(3'h4, 3'h0, 1'b0, 1'b0, 1'b0));
		cmp_port("osc_enable_sec", 16'h0001, {15'h0000, osc_enable_out[2]});
		req_switch(css_pkg::CODE_FRC, 8'h01);
		bus_idle(4);
		rd_chk(css_pkg::ADDR_CTRL, 16'h7001, ctrl(3'h4, 3'h0, 1'b0, 1'b0, 1'b0));
		cmp_port("switch_busy_out", 16'h0000, {15'h0000, switch_busy_out});
		tally_and_finish();
	end

endmodule // tb_top

`default_nettype wire
